// file: dv/alu_flag_model.sv
// partner: flag generator of the alu datapath beyond the register set
// assumes operands are driven by the bench away from the rising edge
`timescale 1ns/1ns
`default_nettype none
module alu_flag_model (
  // operands
  input wire logic [15:0] op_a_i,
  input wire logic [15:0] op_b_i,
  // flags toward the register set
  output wire sbus_regs_pkg::alu_flags_s flags_o
);
  logic [16:0] sum;
  assign sum = {1'b0, op_a_i} + {1'b0, op_b_i};
  assign flags_o.carry = sum[16];
  assign flags_o.overflow = (op_a_i[15] == op_b_i[15]) &&
                            (sum[15] != op_a_i[15]);
  assign flags_o.zero = (sum[15:0] == 16'h0000);
  assign flags_o.negative = sum[15];
endmodule // alu_flag_model
`default_nettype wire

// file: dv/tb_top.sv
// testbench of the s-bus register set: drives decoded micro words
// assumes one 125 MHz clock; inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  `define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
  typedef struct {int due; int sel; logic [15:0] exp;} note_s;
  localparam int O_SBUS = 0, O_STAT = 1, O_OCC = 2, O_CMAX = 3;
  localparam int O_FBUF = 4, O_MOD = 5, O_PRE = 6, O_LEFT = 7, O_RIGHT = 8;
  localparam int O_SER = 9;
  logic clk_i, reset_n_i, halt_entry, load_r, load_s, fetch_inc, sp3_ser;
  sbus_regs_pkg::micro_s micro;
  sbus_regs_pkg::alu_flags_s flags;
  logic [15:0] u_bus, r_bus, index, disp, op_a, op_b;
  logic [15:0] s_bus, left, right, fbuf, pre, status, e, w, a1;
  logic [2:0] fmod, occ;
  logic [1:0] valid_lower;
  logic cmax, ser_out;
  logic [16:0] sum;
  logic [15:0] vals [10];
  int occ_code [9] = '{2, 3, 4, 1, 5, 2, 1, 1, 1};
  int occ_cnt [9] = '{3, 2, 3, 4, 0, 0, 1, 2, 3};
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  note_s notes[$];

  alu_flag_model alu_flag_model_i (.op_a_i(op_a), .op_b_i(op_b),
    .flags_o(flags));
  sbus_register_file sbus_register_file_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .micro_i(micro),
    .halt_entry_i(halt_entry), .u_bus_i(u_bus), .r_bus_i(r_bus),
    .load_r_latch_i(load_r), .load_s_latch_i(load_s),
    .fetch_increment_i(fetch_inc), .sp3_serial_i(sp3_ser),
    .alu_flags_i(flags), .index_i(index), .displacement_i(disp),
    .s_bus_o(s_bus), .left_operand_o(left), .right_operand_o(right),
    .fetch_address_output_buffer_o(fbuf), .fetch_module_o(fmod),
    .pre_adder_o(pre), .tos_in_use_count_o(occ),
    .tos_valid_lower_o(valid_lower), .counter_maximum_test_o(cmax),
    .sp3_serial_o(ser_out), .cpu_status_word_o(status));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] observe(input int sel);
    case (sel)
      O_SBUS: return s_bus;
      O_STAT: return status;
      O_OCC: return {11'h000, valid_lower, occ};
      O_CMAX: return {15'h0000, cmax};
      O_FBUF: return fbuf;
      O_MOD: return {13'h0000, fmod};
      O_PRE: return pre;
      O_LEFT: return left;
      O_SER: return {15'h0000, ser_out};
      default: return right;
    endcase
  endfunction
  // expected count plus the two lower-valid flags
  function automatic logic [15:0] occv(input int c);
    return {11'h000, c > 3, c > 2, 3'(c)};
  endfunction
  // notes may fall due out of order, so the whole queue is scanned
  always @(negedge clk_i) begin
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].due == cyc) begin
        `CHK(observe(notes[i].sel), notes[i].exp)
        notes.delete(i);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic note(input int sel, input logic [15:0] x, input int lat);
    notes.push_back('{cyc + lat, sel, x});
  endtask
  task automatic op(input sbus_regs_pkg::micro_s m, input logic [15:0] u);
    micro = m;
    u_bus = u;
    @(negedge clk_i);
  endtask
  task automatic idle();
    op('0, 16'($urandom));
  endtask
  task automatic st(input int d, input logic [15:0] u);
    sbus_regs_pkg::micro_s m;
    m = '0;
    m.dst = sbus_regs_pkg::store_dst_e'(4'(d));
    op(m, u);
  endtask
  task automatic rd(input int s);
    sbus_regs_pkg::micro_s m;
    m = '0;
    m.src = sbus_regs_pkg::sbus_src_e'(4'(s));
    op(m, 16'($urandom));
  endtask
  task automatic sp(input int c);
    sbus_regs_pkg::micro_s m;
    m = '0;
    m.special = sbus_regs_pkg::special_e'(4'(c));
    op(m, 16'($urandom));
  endtask
  task automatic fn(input int f);
    sbus_regs_pkg::micro_s m;
    m = '0;
    m.func = sbus_regs_pkg::function_e'(3'(f));
    op(m, 16'($urandom));
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    micro = '0;
    {halt_entry, load_r, load_s, fetch_inc, sp3_ser} = 5'h00;
    {u_bus, r_bus, index, disp, op_a, op_b} = '0;
    reset_n_i = 1'b0;
    void'($urandom(32'ha3f43876));
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    // store codes 2..9 and read codes 2..9 name the same registers
    for (int k = 2; k < 10; k++) begin
      vals[k] = 16'($urandom);
      st(k, vals[k]);
    end
    for (int k = 2; k < 10; k++) begin
      note(O_SBUS, vals[k], 1);
      rd(k);
    end
    a1 = vals[9] + 16'h0001;
    fetch_inc = 1'b1;
    idle();
    fetch_inc = 1'b0;
    note(O_FBUF, a1, 1);
    note(O_MOD, {13'h0000, a1[2:0] ^ {1'b0, a1[15:14]}}, 1);
    op(sbus_regs_pkg::micro_s'(16'h0001), 16'($urandom));
    // status: whole-word store, then each flag special in turn
    w = 16'($urandom);
    w[7:4] = 4'h8;
    e = w;
    note(O_STAT, e, 2);
    st(11, w);
    for (int k = 7; k < 14; k++) begin
      case (k)
        7: e[5] = 1'b1;
        8: e[5] = 1'b0;
        9: e[4] = 1'b1;
        10: e[4] = 1'b0;
        11: e[7:6] = sbus_regs_pkg::CC_GREATER;
        12: e[7:6] = sbus_regs_pkg::CC_LESS;
        default: e[7:6] = sbus_regs_pkg::CC_EQUAL;
      endcase
      note(O_STAT, e, 2);
      sp(k);
    end
    // add, subtract, increment take their flags from the alu partner
    for (int k = 0; k < 6; k++) begin
      op_a = 16'($urandom);
      op_b = (k == 0) ? -op_a : 16'($urandom);
      sum = {1'b0, op_a} + {1'b0, op_b};
      e[5] = sum[16];
      e[4] = (op_a[15] == op_b[15]) && (sum[15] != op_a[15]);
      e[7:6] = sum[15] ? sbus_regs_pkg::CC_LESS : sbus_regs_pkg::CC_GREATER;
      if (sum[15:0] == 16'h0000) e[7:6] = sbus_regs_pkg::CC_EQUAL;
      note(O_STAT, e, 2);
      fn(1 + k % 3);
    end
    // zero-test special: equal on a zero sum, otherwise greater
    for (int k = 0; k < 2; k++) begin
      op_a = 16'($urandom);
      op_b = (k == 0) ? -op_a : ~op_a;
      e[7:6] = (k == 0) ? sbus_regs_pkg::CC_EQUAL : sbus_regs_pkg::CC_GREATER;
      note(O_STAT, e, 2);
      sp(14);
    end
    repeat (3) idle();
    reset_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    note(O_STAT, {e[15:8], 8'h00}, 2);
    repeat (2) idle();
    // occupancy: pushes saturate at four, then the special codes
    note(O_OCC, occv(0), 2);
    sp(5);
    for (int k = 1; k < 6; k++) begin
      note(O_OCC, occv(k > 4 ? 4 : k), 2);
      st(1, 16'($urandom));
    end
    for (int k = 0; k < 9; k++) begin
      note(O_OCC, occv(occ_cnt[k]), 2);
      sp(occ_code[k]);
    end
    note(O_SBUS, 16'h0003, 1);
    rd(1);
    halt_entry = 1'b1;
    idle();
    halt_entry = 1'b0;
    note(O_SBUS, 16'h0003, 1);
    rd(10);
    // repeat count loaded with minus three counts up through all ones to zero
    st(10, 16'hfffd);
    note(O_CMAX, 16'h0000, 2);
    sp(6);
    note(O_CMAX, 16'h0001, 2);
    sp(6);
    note(O_CMAX, 16'h0000, 2);
    sp(6);
    note(O_SBUS, 16'h0000, 1);
    rd(10);
    // scratch three shifts under all three shifting function codes
    w = 16'($urandom);
    st(8, w);
    for (int k = 0; k < 3; k++) begin
      sp3_ser = 1'($urandom);
      w = {w[14:0], sp3_ser};
      fn(k == 2 ? 7 : 4 + k);
    end
    note(O_SBUS, w, 1);
    note(O_SER, {15'h0000, w[15]}, 1);
    rd(8);
    for (int k = 0; k < 6; k++) begin
      index = 16'($urandom);
      disp = 16'($urandom);
      note(O_PRE, index + disp, 1);
      idle();
    end
    r_bus = 16'($urandom);
    load_r = 1'b1;
    note(O_LEFT, r_bus, 1);
    idle();
    load_r = 1'b0;
    note(O_LEFT, {r_bus[14:0], 1'b0}, 1);
    fn(6);
    w = 16'($urandom);
    st(7, w);
    rd(7);
    load_s = 1'b1;
    note(O_RIGHT, w, 1);
    rd(7);
    load_s = 1'b0;
    note(O_RIGHT, w, 1);
    rd(7);
    note(O_RIGHT, {1'b0, w[15:1]}, 1);
    fn(7);
    repeat (4) idle();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

// file: hw/sbus_register_file.sv
// s-bus side register set of a 16-bit stack cpu datapath
// assumes the microinstruction decoder presents one decoded micro word
// per cycle and the cycle ends on the rising clk_i edge
//
// Overview of operation
// - three-bit count of valid top-of-stack registers
// - count read on bus, changed by stack codes
// - count two means only two registers valid
// - code segment base readable and store loadable
// - data floor readable and store loadable
// - stack memory top zero-four below top
// - data area base readable and store loadable
// - stack marker readable and store loadable
// - scratch two general temporary, read and written
// - scratch three shifts left, serial in/out
// - advance fetch encodes module, copies fetch address
// - fetch address increments, readable, store loadable
// - repeat count loaded negated, counts up, all-ones test
// - halt entry saves occupancy count into repeat count
// - cpu reset clears status low byte only
// - status bit 0 privileged mode
// - bits 1,2 enable interrupts and user traps
// - bit 3 stack op pending, 4 overflow, 5 carry
// - bits 6,7 condition code, 11 not used
// - bits 8-15 segment number, whole word read/store
// - arithmetic and special codes update flags
// - pre-adder adds displacement to index
// - left operand latch loads r-bus, shifts left
// - right operand latch loads s-bus, shifts right
`timescale 1ns/1ns
`default_nettype none
module sbus_register_file (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // decoded microinstruction
  input wire sbus_regs_pkg::micro_s micro_i,
  input wire logic halt_entry_i,
  // data paths
  input wire logic [15:0] u_bus_i,
  input wire logic [15:0] r_bus_i,
  input wire logic load_r_latch_i,
  input wire logic load_s_latch_i,
  input wire logic fetch_increment_i,
  input wire logic sp3_serial_i,
  input wire sbus_regs_pkg::alu_flags_s alu_flags_i,
  // pre-adder operands
  input wire logic [15:0] index_i,
  input wire logic [15:0] displacement_i,
  // outputs
  output logic [15:0] s_bus_o,
  output logic [15:0] left_operand_o,
  output logic [15:0] right_operand_o,
  output logic [15:0] fetch_address_output_buffer_o,
  output logic [2:0] fetch_module_o,
  output logic [15:0] pre_adder_o,
  output logic [2:0] tos_in_use_count_o,
  output logic [1:0] tos_valid_lower_o,
  output logic counter_maximum_test_o,
  output logic sp3_serial_o,
  output logic [15:0] cpu_status_word_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [2:0] tos_in_use_count_r;
  logic [15:0] code_segment_base_r;
  logic [15:0] data_floor_r;
  logic [15:0] stack_memory_top_r;
  logic [15:0] data_area_base_r;
  logic [15:0] stack_marker_r;
  logic [15:0] scratch_two_r;
  logic [15:0] scratch_three_shifter_r;
  logic [15:0] instruction_fetch_address_r;
  logic [5:0] repeat_count_r;
  logic [7:0] status_low_r;
  logic [7:0] status_high_r;
  logic [15:0] sbus_nxt;
  logic [7:0] status_low_nxt;
  logic [15:0] status_word;
  logic sp3_shift;

  assign status_word = {status_high_r, status_low_r};
  assign sp3_shift = (micro_i.func == sbus_regs_pkg::FN_MULT_STEP) ||
                     (micro_i.func == sbus_regs_pkg::FN_COUNT_DIVIDE) ||
                     (micro_i.func == sbus_regs_pkg::FN_RIGHT_SHIFT);

  // memory module number from fetch address bits 0,1,2,14,15; the module
  // map is a plain interleave here, real boards strap it
  function automatic logic [2:0] module_of(input logic [15:0] a);
    module_of = a[2:0] ^ {1'b0, a[15:14]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // s-bus read mux
  always_comb begin
    case (micro_i.src)
      sbus_regs_pkg::SRC_OCC: sbus_nxt = {13'h0000, tos_in_use_count_r};
      sbus_regs_pkg::SRC_CSB: sbus_nxt = code_segment_base_r;
      sbus_regs_pkg::SRC_DFL: sbus_nxt = data_floor_r;
      sbus_regs_pkg::SRC_SMT: sbus_nxt = stack_memory_top_r;
      sbus_regs_pkg::SRC_DAB: sbus_nxt = data_area_base_r;
      sbus_regs_pkg::SRC_MRK: sbus_nxt = stack_marker_r;
      sbus_regs_pkg::SRC_SP2: sbus_nxt = scratch_two_r;
      sbus_regs_pkg::SRC_SP3: sbus_nxt = scratch_three_shifter_r;
      sbus_regs_pkg::SRC_FETCH: sbus_nxt = instruction_fetch_address_r;
      sbus_regs_pkg::SRC_RPT: sbus_nxt = {10'h000, repeat_count_r};
      sbus_regs_pkg::SRC_STAT: sbus_nxt = status_word;
      default: sbus_nxt = sbus_regs_pkg::WORD_RESET;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_bus_o <= sbus_regs_pkg::WORD_RESET;
    end else begin
      s_bus_o <= sbus_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // occupancy counter, saturating at four and zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tos_in_use_count_r <= 3'h0;
    end else begin
      case (micro_i.special)
        sbus_regs_pkg::SPC_OCC_INC, sbus_regs_pkg::SPC_POPA: begin
          // pop-a reloads a register from memory, adding one in use
          if (tos_in_use_count_r != sbus_regs_pkg::OCC_MAX) begin
            tos_in_use_count_r <= tos_in_use_count_r + 3'h1;
          end
        end
        sbus_regs_pkg::SPC_OCC_DEC, sbus_regs_pkg::SPC_POP: begin
          if (tos_in_use_count_r != 3'h0) begin
            tos_in_use_count_r <= tos_in_use_count_r - 3'h1;
          end
        end
        sbus_regs_pkg::SPC_OCC_ZERO: tos_in_use_count_r <= 3'h0;
        default: begin
          if (micro_i.dst == sbus_regs_pkg::DST_PUSH &&
              tos_in_use_count_r != sbus_regs_pkg::OCC_MAX) begin
            tos_in_use_count_r <= tos_in_use_count_r + 3'h1;
          end
        end
      endcase
    end
  end

  // deeper two registers valid only when the count reaches them
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tos_in_use_count_o <= 3'h0;
      tos_valid_lower_o <= 2'h0;
    end else begin
      tos_in_use_count_o <= tos_in_use_count_r;
      tos_valid_lower_o <= {tos_in_use_count_r > 3'h3,
                            tos_in_use_count_r > 3'h2};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointer and scratch registers, loaded from the u-bus
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_segment_base_r <= sbus_regs_pkg::WORD_RESET;
      data_floor_r <= sbus_regs_pkg::WORD_RESET;
      stack_memory_top_r <= sbus_regs_pkg::WORD_RESET;
      data_area_base_r <= sbus_regs_pkg::WORD_RESET;
      stack_marker_r <= sbus_regs_pkg::WORD_RESET;
      scratch_two_r <= sbus_regs_pkg::WORD_RESET;
    end else begin
      case (micro_i.dst)
        sbus_regs_pkg::DST_CSB: code_segment_base_r <= u_bus_i;
        sbus_regs_pkg::DST_DFL: data_floor_r <= u_bus_i;
        sbus_regs_pkg::DST_SMT: stack_memory_top_r <= u_bus_i;
        sbus_regs_pkg::DST_DAB: data_area_base_r <= u_bus_i;
        sbus_regs_pkg::DST_MRK: stack_marker_r <= u_bus_i;
        sbus_regs_pkg::DST_SP2: scratch_two_r <= u_bus_i;
        default: ;
      endcase
    end
  end

  // store wins over shift if microcode asks for both
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scratch_three_shifter_r <= sbus_regs_pkg::WORD_RESET;
    end else if (micro_i.dst == sbus_regs_pkg::DST_SP3) begin
      scratch_three_shifter_r <= u_bus_i;
    end else if (sp3_shift) begin
      scratch_three_shifter_r <= {scratch_three_shifter_r[14:0],
                                  sp3_serial_i};
    end
  end

  // serial out follows bit 15, the bit that each shift pushes out
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sp3_serial_o <= 1'b0;
    end else begin
      sp3_serial_o <= scratch_three_shifter_r[15];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fetch address: store beats increment
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      instruction_fetch_address_r <= sbus_regs_pkg::WORD_RESET;
    end else if (micro_i.dst == sbus_regs_pkg::DST_FETCH) begin
      instruction_fetch_address_r <= u_bus_i;
    end else if (fetch_increment_i) begin
      instruction_fetch_address_r <= instruction_fetch_address_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fetch_address_output_buffer_o <= sbus_regs_pkg::WORD_RESET;
      fetch_module_o <= 3'h0;
    end else if (micro_i.advance_fetch) begin
      fetch_address_output_buffer_o <= instruction_fetch_address_r;
      fetch_module_o <= module_of(instruction_fetch_address_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // repeat counter; halt capture has priority over microcode
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      repeat_count_r <= 6'h00;
    end else if (halt_entry_i) begin
      repeat_count_r <= {3'h0, tos_in_use_count_r};
    end else if (micro_i.dst == sbus_regs_pkg::DST_RPT) begin
      repeat_count_r <= u_bus_i[5:0];
    end else if (micro_i.special == sbus_regs_pkg::SPC_RPT_INC) begin
      repeat_count_r <= repeat_count_r + 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      counter_maximum_test_o <= 1'b0;
    end else begin
      counter_maximum_test_o <=
        (repeat_count_r == sbus_regs_pkg::RPT_ALL_ONES);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status word low byte: store first, then function, then special codes
  always_comb begin
    status_low_nxt = status_low_r;
    if (micro_i.dst == sbus_regs_pkg::DST_STAT) begin
      status_low_nxt = u_bus_i[7:0];
    end
    case (micro_i.func)
      sbus_regs_pkg::FN_ADD, sbus_regs_pkg::FN_SUB, sbus_regs_pkg::FN_INC:
      begin
        status_low_nxt[sbus_regs_pkg::ST_CARRY] = alu_flags_i.carry;
        status_low_nxt[sbus_regs_pkg::ST_OVF] = alu_flags_i.overflow;
        status_low_nxt[sbus_regs_pkg::ST_CC_HI:sbus_regs_pkg::ST_CC_LO] =
          alu_flags_i.zero ? sbus_regs_pkg::CC_EQUAL :
          alu_flags_i.negative ? sbus_regs_pkg::CC_LESS :
          sbus_regs_pkg::CC_GREATER;
      end
      default: ;
    endcase
    case (micro_i.special)
      sbus_regs_pkg::SPC_SET_CARRY:
        status_low_nxt[sbus_regs_pkg::ST_CARRY] = 1'b1;
      sbus_regs_pkg::SPC_CLR_CARRY:
        status_low_nxt[sbus_regs_pkg::ST_CARRY] = 1'b0;
      sbus_regs_pkg::SPC_SET_OVF:
        status_low_nxt[sbus_regs_pkg::ST_OVF] = 1'b1;
      sbus_regs_pkg::SPC_CLR_OVF:
        status_low_nxt[sbus_regs_pkg::ST_OVF] = 1'b0;
      sbus_regs_pkg::SPC_CC_GREATER:
        status_low_nxt[7:6] = sbus_regs_pkg::CC_GREATER;
      sbus_regs_pkg::SPC_CC_LESS:
        status_low_nxt[7:6] = sbus_regs_pkg::CC_LESS;
      sbus_regs_pkg::SPC_CC_EQUAL:
        status_low_nxt[7:6] = sbus_regs_pkg::CC_EQUAL;
      sbus_regs_pkg::SPC_CC_ZERO_TEST:
        status_low_nxt[7:6] = alu_flags_i.zero ? sbus_regs_pkg::CC_EQUAL :
                              sbus_regs_pkg::CC_GREATER;
      default: ;
    endcase
  end

  // only the low byte sees cpu reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_low_r <= sbus_regs_pkg::STATUS_LOW_RESET;
    end else begin
      status_low_r <= status_low_nxt;
    end
  end

  // no reset: the segment number survives cpu reset
  always_ff @(posedge clk_i) begin
    if (micro_i.dst == sbus_regs_pkg::DST_STAT) begin
      status_high_r <= u_bus_i[15:8];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_status_word_o <= sbus_regs_pkg::WORD_RESET;
    end else begin
      cpu_status_word_o <= status_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operand latches and pre-adder
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      left_operand_o <= sbus_regs_pkg::WORD_RESET;
    end else if (micro_i.func == sbus_regs_pkg::FN_LEFT_SHIFT) begin
      left_operand_o <= {left_operand_o[14:0], 1'b0};
    end else if (load_r_latch_i) begin
      left_operand_o <= r_bus_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      right_operand_o <= sbus_regs_pkg::WORD_RESET;
    end else if (micro_i.func == sbus_regs_pkg::FN_RIGHT_SHIFT) begin
      right_operand_o <= {1'b0, right_operand_o[15:1]};
    end else if (load_s_latch_i) begin
      right_operand_o <= s_bus_o;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_adder_o <= sbus_regs_pkg::WORD_RESET;
    end else begin
      pre_adder_o <= index_i + displacement_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_halt_capture: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    halt_entry_i |=> repeat_count_r == {3'h0, $past(tos_in_use_count_r)})
    else $error("halt did not save occupancy");
  a_occ_bound: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tos_in_use_count_r <= sbus_regs_pkg::OCC_MAX)
    else $error("occupancy above four");
  a_occ_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    micro_i.special == sbus_regs_pkg::SPC_OCC_ZERO |=>
      tos_in_use_count_r == 3'h0)
    else $error("zeroing code failed");
  a_ctr_max: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    repeat_count_r == sbus_regs_pkg::RPT_ALL_ONES |=> counter_maximum_test_o)
    else $error("counter maximum missed");
  a_fetch_copy: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    micro_i.advance_fetch |=>
      fetch_address_output_buffer_o == $past(instruction_fetch_address_r))
    else $error("fetch buffer not loaded");
  a_fetch_inc: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    fetch_increment_i && micro_i.dst != sbus_regs_pkg::DST_FETCH |=>
      instruction_fetch_address_r ==
        $past(instruction_fetch_address_r) + 16'h0001)
    else $error("fetch address not incremented");
  a_sp3_shift: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sp3_shift && micro_i.dst != sbus_regs_pkg::DST_SP3 |=>
      scratch_three_shifter_r[0] == $past(sp3_serial_i))
    else $error("sp3 serial input lost");
  a_hold_dab: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    micro_i.dst != sbus_regs_pkg::DST_DAB |=> $stable(data_area_base_r))
    else $error("data base changed unselected");
  a_preadd_sum: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 pre_adder_o == $past(index_i) + $past(displacement_i))
    else $error("pre-adder sum wrong");
endmodule // sbus_register_file
`default_nettype wire

// file: hw/sbus_regs_pkg.sv
// package: codes, status layout, reset values for the s-bus register set
// assumes one cpu clock; field codes arrive already decoded as enums
package sbus_regs_pkg;
  // s-bus read sources
  typedef enum logic [3:0] {
    SRC_NONE, SRC_OCC, SRC_CSB, SRC_DFL, SRC_SMT, SRC_DAB, SRC_MRK,
    SRC_SP2, SRC_SP3, SRC_FETCH, SRC_RPT, SRC_STAT
  } sbus_src_e;
  // store destinations
  typedef enum logic [3:0] {
    DST_NONE, DST_PUSH, DST_CSB, DST_DFL, DST_SMT, DST_DAB, DST_MRK,
    DST_SP2, DST_SP3, DST_FETCH, DST_RPT, DST_STAT
  } store_dst_e;
  // special codes
  typedef enum logic [3:0] {
    SPC_NONE, SPC_OCC_INC, SPC_OCC_DEC, SPC_POP, SPC_POPA, SPC_OCC_ZERO,
    SPC_RPT_INC, SPC_SET_CARRY, SPC_CLR_CARRY, SPC_SET_OVF, SPC_CLR_OVF,
    SPC_CC_GREATER, SPC_CC_LESS, SPC_CC_EQUAL, SPC_CC_ZERO_TEST
  } special_e;
  // function codes
  typedef enum logic [2:0] {
    FN_NONE, FN_ADD, FN_SUB, FN_INC, FN_MULT_STEP, FN_COUNT_DIVIDE,
    FN_LEFT_SHIFT, FN_RIGHT_SHIFT
  } function_e;
  typedef struct packed {
    sbus_src_e  src;
    store_dst_e dst;
    special_e   special;
    function_e  func;
    logic       advance_fetch;
  } micro_s;
  typedef struct packed {
    logic carry;
    logic overflow;
    logic zero;
    logic negative;
  } alu_flags_s;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned OCC_W = 3;
  localparam int unsigned RPT_W = 6;
  localparam logic [2:0] OCC_MAX = 3'h4;
  localparam int unsigned ST_PRIV = 0;
  localparam int unsigned ST_EXT_INT = 1;
  localparam int unsigned ST_USER_TRAP = 2;
  localparam int unsigned ST_STACK_OP_B = 3;
  localparam int unsigned ST_OVF = 4;
  localparam int unsigned ST_CARRY = 5;
  localparam int unsigned ST_CC_LO = 6;
  localparam int unsigned ST_CC_HI = 7;
  localparam int unsigned ST_SEG_LO = 8;
  localparam logic [1:0] CC_GREATER = 2'h0;
  localparam logic [1:0] CC_LESS = 2'h1;
  localparam logic [1:0] CC_EQUAL = 2'h2;
  localparam logic [7:0] STATUS_LOW_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [5:0] RPT_ALL_ONES = 6'h3f;
endpackage
